// ### core/ftpc_pkg.sv
package ftpc_pkg;

  // ==========================================
  // Register map (word byte addresses)
  localparam logic [3:0] FTPC_OFS_CTRL = 4'h0;
  localparam logic [3:0] FTPC_OFS_SEL = 4'h4;
  localparam logic [3:0] FTPC_OFS_STATUS = 4'h8;
  localparam logic [3:0] FTPC_OFS_RESULT = 4'hC;

  // ==========================================
  // Descriptor field positions (64-bit descriptor)
  localparam int FTPC_GATE_OFS_LO_POS = 0;
  localparam int FTPC_GATE_SEL_POS = 16;
  localparam int FTPC_GATE_CNT_POS = 32;
  localparam int FTPC_TYPE_POS = 40;
  localparam int FTPC_DPL_POS = 45;
  localparam int FTPC_P_POS = 47;
  localparam int FTPC_GATE_OFS_HI_POS = 48;
  localparam int FTPC_CONF_POS = 42;
  localparam int FTPC_BASE_LO_POS = 16;
  localparam int FTPC_BASE_MID_POS = 32;
  localparam int FTPC_BASE_HI_POS = 56;

  // ==========================================
  // Gate type codes and reset values
  localparam logic [4:0] FTPC_TYPE_GATE16 = 5'h04;
  localparam logic [4:0] FTPC_TYPE_GATE32 = 5'h0C;
  localparam logic [1:0] FTPC_CPL_RESET = 2'h0;
  localparam logic [1:0] FTPC_TABLE_GLOBAL = 2'h0;
  localparam logic [1:0] FTPC_TABLE_LOCAL = 2'h1;
  localparam logic [1:0] FTPC_TABLE_INTR = 2'h2;

  // ==========================================
  // Result codes
  typedef enum logic [1:0] {FTPC_OK, FTPC_PROT_FAULT, FTPC_ABSENT_FAULT} ftpc_fault_t;

  // Privilege check inputs
  typedef struct packed {
    logic [1:0] current_privilege_level;
    logic [1:0] selector_request_level;
    logic [1:0] dest_dpl;
    logic conforming;
    logic is_call;
  } ftpc_priv_in_t;

  // Decoded gate fields
  typedef struct packed {
    logic [15:0] sel;
    logic [31:0] offset;
    logic [4:0] count;
    logic is32;
    logic [1:0] descriptor_privilege_level;
    logic present;
    logic is_gate;
  } ftpc_gate_t;

  // Check verdict
  typedef struct packed {
    ftpc_fault_t fault;
    logic [1:0] new_cpl;
    logic stack_switch;
  } ftpc_verdict_t;

endpackage

// ### core/ftpc_gate_decode.sv
`timescale 1ns/1ns
module ftpc_gate_decode
  import ftpc_pkg::*;
(
  input wire logic [63:0] i_desc,
  output ftpc_gate_t o_gate
);

  // ==========================================
  // Field extraction from a gate descriptor
  always_comb
  begin
    o_gate.sel = i_desc[FTPC_GATE_SEL_POS +: 16]; // see [R8]
    o_gate.offset = {i_desc[FTPC_GATE_OFS_HI_POS +: 16], i_desc[FTPC_GATE_OFS_LO_POS +: 16]}; // see [R8]
    o_gate.count = i_desc[FTPC_GATE_CNT_POS +: 5]; // see [R9]
    o_gate.is32 = (i_desc[FTPC_TYPE_POS +: 5] == FTPC_TYPE_GATE32); // see [R10]
    o_gate.descriptor_privilege_level = i_desc[FTPC_DPL_POS +: 2]; // see [R13]
    o_gate.present = i_desc[FTPC_P_POS]; // see [R11]
    o_gate.is_gate = (i_desc[FTPC_TYPE_POS +: 5] == FTPC_TYPE_GATE32)
      || (i_desc[FTPC_TYPE_POS +: 5] == FTPC_TYPE_GATE16);
  end

endmodule

// ### core/ftpc_priv_check.sv
`timescale 1ns/1ns
module ftpc_priv_check
  import ftpc_pkg::*;
(
  input wire ftpc_priv_in_t i_chk,
  input wire logic i_via_gate,
  output ftpc_verdict_t o_verdict
);

  // ==========================================
  // Destination code segment privilege check
  always_comb
  begin
    o_verdict.fault = FTPC_OK;
    o_verdict.new_cpl = i_chk.current_privilege_level;
    o_verdict.stack_switch = 1'b0;
    if (i_chk.conforming)
    begin
      // Selector request level ignored, level kept
      if (i_chk.current_privilege_level < i_chk.dest_dpl) // see [R4] see [R5] see [R6] see [R20]
        o_verdict.fault = FTPC_PROT_FAULT;
    end
    else if (!i_via_gate)
    begin
      if ((i_chk.current_privilege_level != i_chk.dest_dpl) || (i_chk.selector_request_level > i_chk.current_privilege_level)) // see [R1] see [R2]
        o_verdict.fault = FTPC_PROT_FAULT;
    end
    else if (i_chk.is_call)
    begin
      if (i_chk.dest_dpl > i_chk.current_privilege_level) // see [R18]
        o_verdict.fault = FTPC_PROT_FAULT;
      else if (i_chk.dest_dpl < i_chk.current_privilege_level)
      begin
        o_verdict.new_cpl = i_chk.dest_dpl; // see [R19]
        o_verdict.stack_switch = 1'b1;
      end
    end
    else if (i_chk.dest_dpl != i_chk.current_privilege_level) // see [R18]
      o_verdict.fault = FTPC_PROT_FAULT;
  end

endmodule

// ### core/ftpc_top.sv
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
// Overview of operation
// [R1] Direct nonconforming: fault unless levels equal
// [R2] Direct nonconforming: request level at most current
// [R3] Code selector keeps current level, not request
// [R4] Conforming: fault only if current below target
// [R5] Conforming: request level never checked
// [R6] Conforming: level unchanged, no stack switch
// [R7] Gates from global/local tables only
// [R8] Target selector and entry from gate
// [R9] Parameter count copied, words or doublewords
// [R10] Gate type sets push size
// [R11] Absent gate raises absent segment fault
// [R12] Gate and target presence checked separately
// [R13] Gate level guards reaching the procedure
// [R14] Pointer offset ignored for gate targets
// [R15] Entry address is target base plus offset
// [R16] Gate check uses four level inputs
// [R17] Current and request levels at most gate
// [R18] Call/branch destination level rules through gates
// [R19] Call to higher level lowers level, switches stack
// [R20] Levels are 2-bit numeric, zero most privileged
module ftpc_top
  import ftpc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_start,
  input wire logic i_is_call,
  input wire logic [15:0] i_ptr_sel,
  input wire logic [31:0] i_ptr_offset,
  input wire logic [1:0] i_gate_table,
  input wire logic [63:0] i_gate_desc,
  input wire logic [63:0] i_dest_desc,
  output logic o_done,
  output logic [1:0] o_fault,
  output logic [15:0] o_cs_sel,
  output logic [31:0] o_entry_addr,
  output logic [1:0] o_cpl,
  output logic o_stack_switch,
  output logic [4:0] o_param_count,
  output logic o_push32
);

  // ==========================================
  // State
  typedef enum logic [1:0] {FTPC_IDLE, FTPC_EVAL, FTPC_ACK} ftpc_state_t;

  typedef struct packed {
    ftpc_state_t state;
    logic via_gate;
    logic [1:0] current_privilege_level;
    logic done;
    logic [1:0] fault;
    logic [15:0] cs_sel;
    logic [31:0] entry;
    logic stack_switch;
    logic [4:0] count;
    logic push32;
    logic [31:0] rdata;
  } ftpc_regs_t;

  ftpc_regs_t st_reg;
  ftpc_regs_t st_next;
  ftpc_gate_t gate;
  ftpc_priv_in_t chk;
  ftpc_verdict_t verdict;
  logic [31:0] dest_base;
  logic dest_present;
  logic gate_ok_level;
  logic [1:0] gate_rpl;

  // Base extraction from a code segment descriptor
  function automatic logic [31:0] ftpc_base(input logic [63:0] d);
    ftpc_base = {d[FTPC_BASE_HI_POS +: 8], d[FTPC_BASE_MID_POS +: 8], d[FTPC_BASE_LO_POS +: 16]};
  endfunction

  ftpc_gate_decode u_dec (
    .i_desc(i_gate_desc),
    .o_gate(gate)
  );

  // ==========================================
  // Privilege inputs
  always_comb
  begin
    chk.current_privilege_level = st_reg.current_privilege_level;
    chk.selector_request_level = st_reg.via_gate ? gate_rpl : i_ptr_sel[1:0];
    chk.dest_dpl = i_dest_desc[FTPC_DPL_POS +: 2];
    chk.conforming = i_dest_desc[FTPC_CONF_POS];
    chk.is_call = i_is_call;
  end

  assign gate_rpl = i_ptr_sel[1:0];
  assign dest_base = ftpc_base(i_dest_desc);
  assign dest_present = i_dest_desc[FTPC_P_POS]; // see [R12]
  assign gate_ok_level = (st_reg.current_privilege_level <= gate.descriptor_privilege_level) && (gate_rpl <= gate.descriptor_privilege_level); // see [R13] see [R16] see [R17]

  ftpc_priv_check u_chk (
    .i_chk(chk),
    .i_via_gate(st_reg.via_gate),
    .o_verdict(verdict)
  );

  // ==========================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      FTPC_IDLE:
      begin
        if (i_start)
        begin
          st_next.via_gate = gate.is_gate && (i_gate_table != FTPC_TABLE_INTR); // see [R7]
          st_next.state = FTPC_EVAL;
        end
      end
      FTPC_EVAL:
      begin
        st_next.state = FTPC_IDLE;
        st_next.done = 1'b1;
        st_next.stack_switch = 1'b0;
        st_next.count = 5'h00;
        st_next.push32 = 1'b0;
        if (gate.is_gate && (i_gate_table == FTPC_TABLE_INTR))
          st_next.fault = FTPC_PROT_FAULT; // see [R7]
        else if (st_reg.via_gate)
        begin
          if (!gate.present)
            st_next.fault = FTPC_ABSENT_FAULT; // see [R11]
          else if (!gate_ok_level)
            st_next.fault = FTPC_PROT_FAULT; // see [R17]
          else if (verdict.fault != FTPC_OK)
            st_next.fault = verdict.fault; // see [R18]
          else if (!dest_present)
            st_next.fault = FTPC_ABSENT_FAULT; // see [R12]
          else
          begin
            st_next.fault = FTPC_OK;
            // Offset from pointer is unused here
            st_next.cs_sel = {gate.sel[15:2], verdict.new_cpl}; // see [R8] see [R14]
            st_next.entry = dest_base + gate.offset; // see [R15]
            st_next.current_privilege_level = verdict.new_cpl; // see [R19]
            st_next.stack_switch = verdict.stack_switch; // see [R19]
            st_next.count = verdict.stack_switch ? gate.count : 5'h00; // see [R9]
            st_next.push32 = gate.is32; // see [R10]
          end
        end
        else if (verdict.fault != FTPC_OK)
          st_next.fault = verdict.fault; // see [R1] see [R4]
        else if (!dest_present)
          st_next.fault = FTPC_ABSENT_FAULT;
        else
        begin
          st_next.fault = FTPC_OK;
          st_next.cs_sel = {i_ptr_sel[15:2], st_reg.current_privilege_level}; // see [R3] see [R6]
          st_next.entry = dest_base + i_ptr_offset;
        end
      end
      default:
        st_next.state = FTPC_IDLE;
    endcase
    // Register bus: one wait cycle then answer
    if ((i_avs_read || i_avs_write) && (st_reg.state != FTPC_ACK) && !(st_reg.state == FTPC_EVAL))
    begin
      if (st_reg.state == FTPC_IDLE && !i_start)
      begin
        st_next.state = FTPC_ACK;
        case (i_avs_address)
          FTPC_OFS_CTRL: st_next.rdata = {30'h0, st_reg.current_privilege_level};
          FTPC_OFS_SEL: st_next.rdata = {16'h0, st_reg.cs_sel};
          FTPC_OFS_STATUS: st_next.rdata = {24'h0, st_reg.push32, st_reg.count, st_reg.fault};
          FTPC_OFS_RESULT: st_next.rdata = st_reg.entry;
          default: st_next.rdata = 32'h0;
        endcase
      end
    end
    else if (st_reg.state == FTPC_ACK)
    begin
      st_next.state = FTPC_IDLE;
      // Write lands on the edge that ends the acknowledge cycle, one edge after the wait drops, never earlier
      if (i_avs_write && (i_avs_address == FTPC_OFS_CTRL) && i_avs_byteenable[0])
        st_next.current_privilege_level = i_avs_writedata[1:0]; // see [R20]
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      st_reg <= '0;
      st_reg.state <= FTPC_IDLE;
      st_reg.current_privilege_level <= FTPC_CPL_RESET;
    end
    else if (i_clk_en)
      st_reg <= st_next;
  end

  // Outputs
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && (st_reg.state != FTPC_ACK);
  assign o_avs_readdata = st_reg.rdata;
  assign o_done = st_reg.done;
  assign o_fault = st_reg.fault;
  assign o_cs_sel = st_reg.cs_sel;
  assign o_entry_addr = st_reg.entry;
  assign o_cpl = st_reg.current_privilege_level;
  assign o_stack_switch = st_reg.stack_switch;
  assign o_param_count = st_reg.count;
  assign o_push32 = st_reg.push32;

  // ==========================================
  // Checks
  property p_conf_keeps_cpl;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && chk.conforming && !gate.is_gate)
      |=> (st_reg.current_privilege_level == $past(st_reg.current_privilege_level)) && !st_reg.stack_switch;
  endproperty
  a_conf_keeps_cpl: assert property (p_conf_keeps_cpl) else $error("conforming changed level"); // see [R6]

  property p_direct_nc;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && !st_reg.via_gate && !chk.conforming && !gate.is_gate
      && chk.current_privilege_level != chk.dest_dpl) |=> (st_reg.fault == FTPC_PROT_FAULT);
  endproperty
  a_direct_nc: assert property (p_direct_nc) else $error("direct nonconforming not faulted"); // see [R1]

  property p_rpl_nc;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && !st_reg.via_gate && !chk.conforming && !gate.is_gate
      && chk.selector_request_level > chk.current_privilege_level) |=> (st_reg.fault == FTPC_PROT_FAULT);
  endproperty
  a_rpl_nc: assert property (p_rpl_nc) else $error("request level not checked"); // see [R2]

  property p_absent;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && st_reg.via_gate && !gate.present)
      |=> (st_reg.fault == FTPC_ABSENT_FAULT) && st_reg.done;
  endproperty
  a_absent: assert property (p_absent) else $error("absent gate not faulted"); // see [R11]

  property p_gate_lvl;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && st_reg.via_gate && gate.present && st_reg.current_privilege_level > gate.descriptor_privilege_level)
      |=> (st_reg.fault == FTPC_PROT_FAULT);
  endproperty
  a_gate_lvl: assert property (p_gate_lvl) else $error("gate level ignored"); // see [R17]

  // Gate evaluation step, then the completed switch step
  sequence s_gate_eval;
    i_clk_en && (st_reg.state == FTPC_EVAL) && st_reg.via_gate;
  endsequence

  sequence s_switch_done;
    st_reg.done && st_reg.stack_switch;
  endsequence

  // Level sampled during evaluation must drop on a switch
  property p_switch;
    @(posedge i_clk_sys) disable iff (i_reset)
    s_gate_eval ##1 s_switch_done |-> (st_reg.current_privilege_level < $past(st_reg.current_privilege_level));
  endproperty
  a_switch: assert property (p_switch) else $error("stack switch without level drop"); // see [R19]

  property p_cs_level;
    @(posedge i_clk_sys) disable iff (i_reset)
    (st_reg.done && st_reg.fault == FTPC_OK) |-> (st_reg.cs_sel[1:0] == st_reg.current_privilege_level);
  endproperty
  a_cs_level: assert property (p_cs_level) else $error("selector level differs from current"); // see [R3]

  property p_conf_fault;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && !gate.is_gate && chk.conforming && chk.current_privilege_level < chk.dest_dpl)
      |=> (st_reg.fault == FTPC_PROT_FAULT);
  endproperty
  a_conf_fault: assert property (p_conf_fault) else $error("conforming fault missed"); // see [R4]

  property p_gate_rpl;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && st_reg.via_gate && gate.present && gate_rpl > gate.descriptor_privilege_level)
      |=> (st_reg.fault == FTPC_PROT_FAULT);
  endproperty
  a_gate_rpl: assert property (p_gate_rpl) else $error("gate request level ignored"); // see [R17]

  property p_intr_gate;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && gate.is_gate && i_gate_table == FTPC_TABLE_INTR)
      |=> (st_reg.fault == FTPC_PROT_FAULT);
  endproperty
  a_intr_gate: assert property (p_intr_gate) else $error("gate in interrupt table accepted"); // see [R7]

  property p_branch_gate;
    @(posedge i_clk_sys) disable iff (i_reset)
    (i_clk_en && st_reg.state == FTPC_EVAL && st_reg.via_gate && gate.present && gate_ok_level
      && !i_is_call && !chk.conforming && chk.dest_dpl != chk.current_privilege_level) |=> (st_reg.fault == FTPC_PROT_FAULT);
  endproperty
  a_branch_gate: assert property (p_branch_gate) else $error("branch changed level through gate"); // see [R18]

  property p_no_switch_count;
    @(posedge i_clk_sys) disable iff (i_reset)
    (st_reg.done && !st_reg.stack_switch) |-> (st_reg.count == 5'h00);
  endproperty
  a_no_switch_count: assert property (p_no_switch_count) else $error("count without switch"); // see [R9]

endmodule

// ### dv/ftpc_top_tb.sv
`timescale 1ns/1ns
`define chk_eq(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ftpc_top_tb;
  import ftpc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hF;
  logic start = 1'b0;
  logic en = 1'b1;
  logic is_call = 1'b0;
  logic [15:0] psel = 16'h0;
  logic [31:0] pofs = 32'h0;
  logic [1:0] tbl = 2'h0;
  logic [63:0] gdesc = 64'h0;
  logic [63:0] ddesc = 64'h0;
  logic [31:0] rdata;
  logic [31:0] entry;
  logic [31:0] q;
  logic [15:0] cs;
  logic [1:0] fault;
  logic [1:0] cpl_o;
  logic [4:0] pcnt;
  logic wait_req;
  logic done;
  logic sw;
  logic p32;
  int n_errors = 0;
  int num_checks = 0;
  int stall = 0;

  // ==========================================
  // Clock, device
  always #10 clk = ~clk;

  ftpc_top dut (.i_clk_sys(clk), .i_reset(rst), .i_clk_en(en), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .i_start(start), .i_is_call(is_call), .i_ptr_sel(psel), .i_ptr_offset(pofs),
    .i_gate_table(tbl), .i_gate_desc(gdesc), .i_dest_desc(ddesc), .o_done(done), .o_fault(fault),
    .o_cs_sel(cs), .o_entry_addr(entry), .o_cpl(cpl_o), .o_stack_switch(sw), .o_param_count(pcnt),
    .o_push32(p32));

  // ==========================================
  // Descriptor builders and reference verdict
  function automatic logic [63:0] gate_d(input logic [15:0] s, input logic [31:0] o, input logic [4:0] n,
    input logic w, input logic [1:0] d, input logic p);
    return {o[31:16], p, d, (w ? FTPC_TYPE_GATE32 : FTPC_TYPE_GATE16), 3'h0, n, s, o[15:0]};
  endfunction

  function automatic logic [63:0] code_d(input logic [31:0] b, input logic [1:0] d, input logic cf,
    input logic p);
    return {b[31:24], 8'hCF, p, d, 2'b11, cf, 2'b10, b[23:0], 16'hFFFF};
  endfunction

  function automatic ftpc_verdict_t model(input logic g, input logic [1:0] t, input logic gp,
    input logic [1:0] gd, input logic [1:0] c, input logic [1:0] r, input logic [1:0] dd,
    input logic cf, input logic cl, input logic dp);
    ftpc_verdict_t v;
    v.fault = FTPC_OK;
    v.new_cpl = c;
    v.stack_switch = 1'b0;
    if (g)
    begin
      if (t == FTPC_TABLE_INTR) v.fault = FTPC_PROT_FAULT;
      else if (!gp) v.fault = FTPC_ABSENT_FAULT;
      else if (c > gd || r > gd) v.fault = FTPC_PROT_FAULT;
      else if (cf ? dd > c : (cl ? dd > c : dd != c)) v.fault = FTPC_PROT_FAULT;
      else if (!cf && dd < c)
      begin
        v.new_cpl = dd;
        v.stack_switch = 1'b1;
      end
    end
    else if (cf ? c < dd : (c != dd || r > c)) v.fault = FTPC_PROT_FAULT;
    if (v.fault == FTPC_OK && !dp) v.fault = FTPC_ABSENT_FAULT;
    return v;
  endfunction

  // ==========================================
  // Register bus and check drivers
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    // Hold the request until the wait is sampled low; only the watchdog ends a hang
    do
    begin
      @(posedge clk);
    end
    while (wait_req !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic xfer(input logic g, input logic [1:0] t, input logic gp, input logic [1:0] gd,
    input logic [1:0] c, input logic [1:0] r, input logic [1:0] dd, input logic cf, input logic cl,
    input logic dp, input logic w32, input logic [4:0] n);
    logic [31:0] base;
    logic [31:0] ofs;
    logic [31:0] po;
    logic [15:0] gs;
    logic [15:0] ps;
    logic [15:0] ecs;
    logic [5:0] est;
    int k;
    ftpc_verdict_t v;
    base = $urandom;
    ofs = $urandom;
    po = $urandom;
    gs = 16'($urandom);
    ps = 16'($urandom);
    ps[1:0] = r;
    if (!w32) ofs[31:16] = 16'h0;
    bus(1'b1, FTPC_OFS_CTRL, {30'h0, c}, q);
    is_call <= cl;
    psel <= ps;
    pofs <= po;
    tbl <= t;
    ddesc <= code_d(base, dd, cf, dp);
    gdesc <= g ? gate_d(gs, ofs, n, w32, gd, gp) : code_d(base, dd, cf, dp);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // Optional freeze of the evaluation through the clock enable
    if (stall > 0) en <= 1'b0;
    repeat (stall)
    begin
      @(posedge clk);
      `chk_eq(done, 1'b0)
    end
    en <= 1'b1;
    k = 0;
    while (done !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    `chk_eq(done, 1'b1)
    v = model(g, t, gp, gd, c, r, dd, cf, cl, dp);
    ecs = {(g ? gs[15:2] : ps[15:2]), v.new_cpl};
    est = (v.fault == FTPC_OK && g) ? {w32, (v.stack_switch ? n : 5'h00)} : 6'h00;
    `chk_eq(fault, v.fault)
    if (v.fault == FTPC_OK)
    begin
      `chk_eq(cpl_o, v.new_cpl)
      `chk_eq(sw, v.stack_switch)
      `chk_eq(cs, ecs)
      if (g)
      begin
        `chk_eq(entry, base + ofs)
        `chk_eq(p32, w32)
        if (v.stack_switch) `chk_eq(pcnt, n)
      end
      else
        `chk_eq(entry, base + po)
    end
    bus(1'b0, FTPC_OFS_STATUS, 32'h0, q);
    `chk_eq(q[7:0], {est, v.fault})
    if (v.fault == FTPC_OK)
    begin
      bus(1'b0, FTPC_OFS_SEL, 32'h0, q);
      `chk_eq(q, {16'h0, ecs})
      bus(1'b0, FTPC_OFS_RESULT, 32'h0, q);
      `chk_eq(q, (g ? base + ofs : base + po))
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Watchdog
  initial
  begin
    #(20 * 20000);
    n_errors++;
    complete_run();
  end

  // ==========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hBDC21F14));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Register map: unmapped read, masked write
    bus(1'b0, 4'h2, 32'h0, q);
    `chk_eq(q, 32'h0)
    bus(1'b1, FTPC_OFS_CTRL, 32'h1, q);
    be <= 4'h0;
    bus(1'b1, FTPC_OFS_CTRL, 32'h3, q);
    be <= 4'hF;
    bus(1'b0, FTPC_OFS_CTRL, 32'h0, q);
    `chk_eq(q[1:0], 2'h1)
    $display("test registers done");
    // Direct transfers
    xfer(0, 0, 1, 0, 2, 2, 2, 0, 1, 1, 0, 0);
    xfer(0, 0, 1, 0, 1, 1, 2, 0, 1, 1, 0, 0);
    xfer(0, 0, 1, 0, 1, 2, 1, 0, 0, 1, 0, 0);
    xfer(0, 1, 1, 0, 2, 0, 2, 0, 1, 1, 0, 0);
    xfer(0, 0, 1, 0, 3, 3, 0, 1, 1, 1, 0, 0);
    xfer(0, 0, 1, 0, 0, 0, 3, 1, 0, 1, 0, 0);
    xfer(0, 0, 1, 0, 1, 3, 1, 1, 0, 1, 0, 0);
    xfer(0, 0, 1, 0, 2, 2, 2, 0, 1, 0, 0, 0);
    // Gate transfers
    xfer(1, 0, 1, 3, 3, 3, 0, 0, 1, 1, 1, 31);
    xfer(1, 1, 1, 2, 2, 1, 1, 0, 1, 1, 0, 5);
    xfer(1, 0, 1, 3, 2, 0, 1, 0, 0, 1, 1, 3);
    xfer(1, 0, 1, 3, 2, 0, 2, 0, 0, 1, 0, 3);
    xfer(1, 1, 1, 3, 3, 3, 1, 1, 0, 1, 1, 7);
    xfer(1, 0, 1, 2, 3, 0, 3, 0, 1, 1, 0, 0);
    xfer(1, 0, 1, 2, 0, 3, 0, 0, 1, 1, 0, 0);
    xfer(1, 2, 1, 3, 0, 0, 0, 0, 1, 1, 1, 1);
    xfer(1, 0, 0, 3, 0, 0, 0, 0, 1, 1, 1, 1);
    xfer(1, 1, 1, 3, 0, 0, 0, 0, 1, 0, 1, 1);
    $display("test corners done");
    // Reset in mid-run: every result back to its reset value
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    `chk_eq({cpl_o, fault, sw, p32, pcnt, cs, entry, done}, {FTPC_CPL_RESET, 58'h0})
    bus(1'b0, FTPC_OFS_CTRL, 32'h0, q);
    `chk_eq(q[1:0], FTPC_CPL_RESET)
    $display("test reset done");
    repeat (200)
    begin
      stall = $urandom_range(0, 3);
      xfer(1'($urandom), 2'($urandom_range(0, 1)), 1'b1, 2'($urandom), 2'($urandom), 2'($urandom),
        2'($urandom), 1'($urandom), 1'($urandom), 1'b1, 1'($urandom), 5'($urandom));
    end
    $display("test random done");
    complete_run();
  end
endmodule
